// >>> gpio_port_pkg.sv
// Package: register map, field positions and reset values of the two-port GPIO block
package gpio_port_pkg;

   // Register bus geometry
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 8;

   // Register offsets
   localparam logic [ADDR_W-1:0] OFS_PORT1_DIRECTION     = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_PORT1_OUTPUT_LATCH  = 4'h1;
   localparam logic [ADDR_W-1:0] OFS_PORT1_PULLUP_ENABLE = 4'h2;
   localparam logic [ADDR_W-1:0] OFS_PIN_FUNCTION_SELECT = 4'h3;
   localparam logic [ADDR_W-1:0] OFS_PORT2_DIRECTION     = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_PORT2_OUTPUT_LATCH  = 4'h5;

   // Port widths
   localparam int unsigned P1_W = 8;
   localparam int unsigned P2_W = 3;

   // Reserved bits: forced to one on data, pull-up and function-select reads, never stored
   localparam logic [DATA_W-1:0] P1_RSVD_MASK  = 8'h08;
   localparam logic [DATA_W-1:0] PFS_RSVD_MASK = 8'h0C;
   localparam logic [DATA_W-1:0] P2_RSVD_MASK  = 8'hF8;

   // Read answers for write-only and unmapped locations
   localparam logic [DATA_W-1:0] DIR_READBACK  = 8'h00;
   localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;

   // Reset values of stored bits
   localparam logic [DATA_W-1:0] RST_DIR  = 8'h00;
   localparam logic [DATA_W-1:0] RST_DATA = 8'h00;
   localparam logic [DATA_W-1:0] RST_PU   = 8'h00;
   localparam logic [DATA_W-1:0] RST_PFS  = 8'h00;

   // Pin-function select fields
   localparam int unsigned PFS_INT3_TRIG = 7;
   localparam int unsigned PFS_INT2      = 6;
   localparam int unsigned PFS_INT1      = 5;
   localparam int unsigned PFS_INT0      = 4;
   localparam int unsigned PFS_TXD       = 1;
   localparam int unsigned PFS_TMR_OUT   = 0;

   // Pin indices that carry alternate functions
   localparam int unsigned P1_PIN_INT3 = 7;
   localparam int unsigned P1_PIN_INT2 = 6;
   localparam int unsigned P1_PIN_INT1 = 5;
   localparam int unsigned P1_PIN_INT0 = 4;
   localparam int unsigned P1_PIN_NONE = 3;
   localparam int unsigned P1_PIN_TMR  = 0;
   localparam int unsigned P2_PIN_TXD  = 2;
   localparam int unsigned P2_PIN_RXD  = 1;
   localparam int unsigned P2_PIN_SCK  = 0;

endpackage : gpio_port_pkg

// >>> pin_sync2.sv
// Two-flop synchroniser for a group of pin levels
`timescale 1ns/100ps
`default_nettype none

module pin_sync2 #(
   parameter int unsigned WIDTH = 8
) (
   // Clock and control
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             ce,
   // Levels
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } sync_state_t;

   sync_state_t s_q;
   sync_state_t s_d;

   // First stage feeds only the second stage
   always_comb begin
      s_d        = s_q;
      s_d.meta   = async_in;
      s_d.stable = s_q.meta;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_q <= '0;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   assign sync_out = s_q.stable;

endmodule : pin_sync2

`default_nettype wire

// >>> pin_cell.sv
// One port pin: chooses between general I/O and an alternate function, registers the pad controls
`timescale 1ns/100ps
`default_nettype none

module pin_cell (
   // Clock and control
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic ce,
   // General I/O settings
   input  wire logic gp_dir,
   input  wire logic gp_data,
   input  wire logic pu_bit,
   // Alternate function
   input  wire logic alt_sel,
   input  wire logic alt_drive,
   input  wire logic alt_data,
   // Pad controls
   output logic      pad_out,
   output logic      pad_oe,
   output logic      pad_pu
);

   typedef struct packed {
      logic out;
      logic oe;
      logic pu;
   } cell_state_t;

   cell_state_t s_q;
   cell_state_t s_d;

   always_comb begin
      s_d = s_q;
      if (alt_sel) begin
         // Alternate function overrides direction and data
         s_d.oe  = alt_drive;
         s_d.out = alt_data;
      end else begin
         s_d.oe  = gp_dir;
         s_d.out = gp_data;
      end
      // Pull-up only on a pin whose direction bit is clear
      s_d.pu = pu_bit & ~gp_dir;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_q <= '0;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   assign pad_out = s_q.out;
   assign pad_oe  = s_q.oe;
   assign pad_pu  = s_q.pu;

endmodule : pin_cell

`default_nettype wire

// >>> port1_port2_gpio_control.sv
// Two-port GPIO control: registers, pin muxing, alternate functions and read-back
//
// Contract
// - Port 1 GPIO pin: dir 1 drives, 0 inputs
// - One direction bit per pin, bit 3 reserved
// - Port 1 data/pull-up bit 3 reads 1
// - Latched port 1 data drives output pins
// - Output-direction bits read back latched value
// - Input-direction bits read back pin level
// - Pull-up bit switches pin pull-up on/off
// - Pull-up acts only while direction is input
// - Pin 7 select feeds interrupt 3, timer trigger
// - Pins 6-4 interrupts, pin 0 timer output
// - Pins 2, 1 are direction-bit GPIO only
// - Port 2 pins 2-0 follow direction; 7-3 reserved
// - Serial claims override port 2 GPIO settings
// - Function select resets 0, documented bit layout
// - Transmit select makes port 2 pin 2 TXD
// - Receiver enable makes port 2 pin 1 RXD
//
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none

module port1_port2_gpio_control
   import gpio_port_pkg::*;
(
   // Clock, reset, enable
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic              ce,
   // Register port
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [DATA_W-1:0] reg_rdata,
   // Port 1 pads
   input  wire logic [P1_W-1:0]   port1_pin_in,
   output logic      [P1_W-1:0]   port1_pin_out,
   output logic      [P1_W-1:0]   port1_pin_oe,
   output logic      [P1_W-1:0]   port1_pin_pullup,
   // Port 2 pads
   input  wire logic [P2_W-1:0]   port2_pin_in,
   output logic      [P2_W-1:0]   port2_pin_out,
   output logic      [P2_W-1:0]   port2_pin_oe,
   // Interrupt and timer sinks
   output logic                   ext_int_line_3,
   output logic                   ext_int_line_2,
   output logic                   ext_int_line_1,
   output logic                   ext_int_line_0,
   output logic                   timer_v_trigger_in,
   input  wire logic              timer_a_clock_out,
   // Serial port unit
   input  wire logic              serial_txd,
   output logic                   serial_rxd,
   input  wire logic              serial_receiver_enable,
   input  wire logic              serial_clk_out_en,
   input  wire logic              serial_clk_in_en,
   input  wire logic              serial_clk_out,
   output logic                   serial_clk_in
);

   typedef struct packed {
      logic [DATA_W-1:0] port1_direction;
      logic [DATA_W-1:0] port1_output_latch;
      logic [DATA_W-1:0] port1_pullup_enable;
      logic [DATA_W-1:0] pin_function_select;
      logic [DATA_W-1:0] port2_direction;
      logic [DATA_W-1:0] port2_output_latch;
      logic [DATA_W-1:0] rdata;
      logic [3:0]        ext_int;
      logic              trig;
      logic              rxd;
      logic              clk_in;
   } gpio_state_t;

   gpio_state_t s_q;
   gpio_state_t s_d;

   logic [P1_W-1:0] p1_sync;
   logic [P2_W-1:0] p2_sync;
   logic [P1_W-1:0] p1_alt_sel;
   logic [P1_W-1:0] p1_alt_drive;
   logic [P1_W-1:0] p1_alt_data;
   logic [P1_W-1:0] p1_dir_eff;
   logic [P2_W-1:0] p2_alt_sel;
   logic [P2_W-1:0] p2_alt_drive;
   logic [P2_W-1:0] p2_alt_data;
   logic [DATA_W-1:0] p1_read;
   logic [DATA_W-1:0] p2_read;
   logic [DATA_W-1:0] p2_dir_ext;
   logic [DATA_W-1:0] p2_sync_ext;

   // Pin levels cross into the clock domain before anything reads them
   pin_sync2 #(.WIDTH(P1_W)) u_sync_p1 (
      .clk      (clk),
      .rst_n    (rst_n),
      .ce       (ce),
      .async_in (port1_pin_in),
      .sync_out (p1_sync)
   );

   pin_sync2 #(.WIDTH(P2_W)) u_sync_p2 (
      .clk      (clk),
      .rst_n    (rst_n),
      .ce       (ce),
      .async_in (port2_pin_in),
      .sync_out (p2_sync)
   );

   // Alternate-function claims on port 1
   always_comb begin
      p1_alt_sel   = '0;
      p1_alt_drive = '0;
      p1_alt_data  = '0;
      p1_alt_sel[P1_PIN_INT3]   = s_q.pin_function_select[PFS_INT3_TRIG];
      p1_alt_sel[P1_PIN_INT2]   = s_q.pin_function_select[PFS_INT2];
      p1_alt_sel[P1_PIN_INT1]   = s_q.pin_function_select[PFS_INT1];
      p1_alt_sel[P1_PIN_INT0]   = s_q.pin_function_select[PFS_INT0];
      p1_alt_sel[P1_PIN_TMR]    = s_q.pin_function_select[PFS_TMR_OUT];
      p1_alt_drive[P1_PIN_TMR]  = 1'b1;
      p1_alt_data[P1_PIN_TMR]   = timer_a_clock_out;
      // Pins 2 and 1 have no claim and stay plain GPIO
      // No pad exists at bit 3, so its direction never drives
      p1_dir_eff = s_q.port1_direction & ~P1_RSVD_MASK;
   end

   // Serial claims on port 2; an external serial clock input wins over clock output
   always_comb begin
      p2_alt_sel   = '0;
      p2_alt_drive = '0;
      p2_alt_data  = '0;
      p2_alt_sel[P2_PIN_TXD]   = s_q.pin_function_select[PFS_TXD];
      p2_alt_drive[P2_PIN_TXD] = 1'b1;
      p2_alt_data[P2_PIN_TXD]  = serial_txd;
      p2_alt_sel[P2_PIN_RXD]   = serial_receiver_enable;
      p2_alt_sel[P2_PIN_SCK]   = serial_clk_out_en | serial_clk_in_en;
      p2_alt_drive[P2_PIN_SCK] = serial_clk_out_en & ~serial_clk_in_en;
      p2_alt_data[P2_PIN_SCK]  = serial_clk_out;
   end

   genvar gi;
   generate
      for (gi = 0; gi < P1_W; gi++) begin : g_p1
         pin_cell u_cell (
            .clk       (clk),
            .rst_n     (rst_n),
            .ce        (ce),
            .gp_dir    (p1_dir_eff[gi]),
            .gp_data   (s_q.port1_output_latch[gi]),
            .pu_bit    (s_q.port1_pullup_enable[gi] & ~P1_RSVD_MASK[gi]),
            .alt_sel   (p1_alt_sel[gi]),
            .alt_drive (p1_alt_drive[gi]),
            .alt_data  (p1_alt_data[gi]),
            .pad_out   (port1_pin_out[gi]),
            .pad_oe    (port1_pin_oe[gi]),
            .pad_pu    (port1_pin_pullup[gi])
         );
      end
      for (gi = 0; gi < P2_W; gi++) begin : g_p2
         pin_cell u_cell (
            .clk       (clk),
            .rst_n     (rst_n),
            .ce        (ce),
            .gp_dir    (s_q.port2_direction[gi]),
            .gp_data   (s_q.port2_output_latch[gi]),
            .pu_bit    (1'b0),
            .alt_sel   (p2_alt_sel[gi]),
            .alt_drive (p2_alt_drive[gi]),
            .alt_data  (p2_alt_data[gi]),
            .pad_out   (port2_pin_out[gi]),
            .pad_oe    (port2_pin_oe[gi]),
            .pad_pu    ()
         );
      end
   endgenerate

   // Read-back of data registers: latch for outputs, synced pin for inputs
   assign p2_dir_ext  = {{(DATA_W-P2_W){1'b0}}, s_q.port2_direction[P2_W-1:0]};
   assign p2_sync_ext = {{(DATA_W-P2_W){1'b0}}, p2_sync};

   always_comb begin
      p1_read = (s_q.port1_direction & s_q.port1_output_latch)
              | (~s_q.port1_direction & p1_sync)
              | P1_RSVD_MASK;
      p2_read = (p2_dir_ext & s_q.port2_output_latch)
              | (~p2_dir_ext & p2_sync_ext)
              | P2_RSVD_MASK;
   end

   always_comb begin
      s_d = s_q;

      // Register writes; reserved bits are never stored
      if (reg_wr) begin
         case (reg_addr)
            OFS_PORT1_DIRECTION:     s_d.port1_direction     = reg_wdata & ~P1_RSVD_MASK;
            OFS_PORT1_OUTPUT_LATCH:  s_d.port1_output_latch  = reg_wdata & ~P1_RSVD_MASK;
            OFS_PORT1_PULLUP_ENABLE: s_d.port1_pullup_enable = reg_wdata & ~P1_RSVD_MASK;
            OFS_PIN_FUNCTION_SELECT: s_d.pin_function_select = reg_wdata & ~PFS_RSVD_MASK;
            OFS_PORT2_DIRECTION:     s_d.port2_direction     = reg_wdata & ~P2_RSVD_MASK;
            OFS_PORT2_OUTPUT_LATCH:  s_d.port2_output_latch  = reg_wdata & ~P2_RSVD_MASK;
            default: ;
         endcase
      end

      // Read data stands for exactly one cycle after the strobe
      s_d.rdata = UNMAPPED_READ;
      if (reg_rd) begin
         case (reg_addr)
            // Direction registers give no read-back; software keeps its own copy
            OFS_PORT1_DIRECTION:     s_d.rdata = DIR_READBACK;
            OFS_PORT2_DIRECTION:     s_d.rdata = DIR_READBACK;
            OFS_PORT1_OUTPUT_LATCH:  s_d.rdata = p1_read;
            OFS_PORT1_PULLUP_ENABLE: s_d.rdata = s_q.port1_pullup_enable | P1_RSVD_MASK;
            OFS_PIN_FUNCTION_SELECT: s_d.rdata = s_q.pin_function_select | PFS_RSVD_MASK;
            OFS_PORT2_OUTPUT_LATCH:  s_d.rdata = p2_read;
            default:                 s_d.rdata = UNMAPPED_READ;
         endcase
      end

      // Alternate inputs see the synced pin only while their select is set
      s_d.ext_int[3] = s_q.pin_function_select[PFS_INT3_TRIG] & p1_sync[P1_PIN_INT3];
      s_d.trig       = s_q.pin_function_select[PFS_INT3_TRIG] & p1_sync[P1_PIN_INT3];
      s_d.ext_int[2] = s_q.pin_function_select[PFS_INT2] & p1_sync[P1_PIN_INT2];
      s_d.ext_int[1] = s_q.pin_function_select[PFS_INT1] & p1_sync[P1_PIN_INT1];
      s_d.ext_int[0] = s_q.pin_function_select[PFS_INT0] & p1_sync[P1_PIN_INT0];
      s_d.rxd        = serial_receiver_enable & p2_sync[P2_PIN_RXD];
      s_d.clk_in     = serial_clk_in_en & p2_sync[P2_PIN_SCK];
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_q.port1_direction     <= RST_DIR;
         s_q.port1_output_latch  <= RST_DATA;
         s_q.port1_pullup_enable <= RST_PU;
         s_q.pin_function_select <= RST_PFS;
         s_q.port2_direction     <= RST_DIR;
         s_q.port2_output_latch  <= RST_DATA;
         s_q.rdata               <= UNMAPPED_READ;
         s_q.ext_int             <= '0;
         s_q.trig                <= 1'b0;
         s_q.rxd                 <= 1'b0;
         s_q.clk_in              <= 1'b0;
      end else if (ce) begin
         s_q <= s_d;
      end
   end

   assign reg_rdata          = s_q.rdata;
   assign ext_int_line_3     = s_q.ext_int[3];
   assign ext_int_line_2     = s_q.ext_int[2];
   assign ext_int_line_1     = s_q.ext_int[1];
   assign ext_int_line_0     = s_q.ext_int[0];
   assign timer_v_trigger_in = s_q.trig;
   assign serial_rxd         = s_q.rxd;
   assign serial_clk_in      = s_q.clk_in;

endmodule : port1_port2_gpio_control

`default_nettype wire

// >>> gpio_port_chk.sv
// Checker: register and pad relations of the two-port GPIO block
`timescale 1ns/100ps
`default_nettype none

module gpio_port_chk
   import gpio_port_pkg::*;
(
   // Clock and reset
   input wire logic              clk,
   input wire logic              rst_n,
   // Register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic              reg_wr,
   input wire logic              reg_rd,
   input wire logic [DATA_W-1:0] reg_rdata,
   // Pads and sinks
   input wire logic [P1_W-1:0]   port1_pin_in,
   input wire logic [P1_W-1:0]   port1_pin_out,
   input wire logic [P1_W-1:0]   port1_pin_oe,
   input wire logic [P1_W-1:0]   port1_pin_pullup,
   input wire logic [P2_W-1:0]   port2_pin_out,
   input wire logic [P2_W-1:0]   port2_pin_oe,
   input wire logic              ext_int_line_3,
   input wire logic              ext_int_line_2,
   input wire logic              timer_v_trigger_in,
   input wire logic              serial_txd,
   input wire logic              serial_rxd,
   input wire logic              serial_receiver_enable
);
   // Shadow copies; valid only while ce stays high
   logic [7:0] dir_q, lat_q, pfs_q;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         {dir_q, lat_q, pfs_q} <= '0;
      end else if (reg_wr) begin
         if (reg_addr == OFS_PORT1_DIRECTION) dir_q <= reg_wdata;
         if (reg_addr == OFS_PORT1_OUTPUT_LATCH) lat_q <= reg_wdata;
         if (reg_addr == OFS_PIN_FUNCTION_SELECT) pfs_q <= reg_wdata;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   dir_read_a: assert property (reg_rd && reg_addr == OFS_PORT1_DIRECTION |=> reg_rdata == DIR_READBACK)
      else $error("bad direction read");
   latch_read_a: assert property (reg_rd && reg_addr == OFS_PORT1_OUTPUT_LATCH |=> reg_rdata[3]
      && ((reg_rdata ^ $past(lat_q)) & $past(dir_q) & 8'hF7) == 8'h00) else $error("bad data read");
   gp_pad_a: assert property (##1 port1_pin_oe[2:1] == $past(dir_q[2:1])
      && ((port1_pin_out[2:1] ^ $past(lat_q[2:1])) & port1_pin_oe[2:1]) == 2'h0) else $error("bad pins 2-1");
   rsvd_pin_a: assert property (!port1_pin_oe[3] && !port1_pin_pullup[3])
      else $error("pin 3 active");
   int_pair_a: assert property (ext_int_line_3 == timer_v_trigger_in)
      else $error("trigger differs");
   int_alt_a: assert property (ext_int_line_2 |-> $past(port1_pin_in[6], 3) && !port1_pin_oe[6])
      else $error("bad interrupt 2");
   tx_claim_a: assert property (pfs_q[PFS_TXD] |=> port2_pin_oe[2] && port2_pin_out[2] == $past(serial_txd))
      else $error("bad transmit pin");
   rx_claim_a: assert property (serial_rxd |-> $past(serial_receiver_enable) && !port2_pin_oe[1])
      else $error("bad receive pin");

   cover property (ext_int_line_2);
   cover property (serial_rxd);
   cover property (pfs_q[PFS_TXD] && serial_txd);
endmodule : gpio_port_chk

bind port1_port2_gpio_control gpio_port_chk gpio_port_chk_i (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
   .reg_rd, .reg_rdata, .port1_pin_in, .port1_pin_out, .port1_pin_oe, .port1_pin_pullup, .port2_pin_out,
   .port2_pin_oe, .ext_int_line_3, .ext_int_line_2, .timer_v_trigger_in, .serial_txd, .serial_rxd,
   .serial_receiver_enable);
`default_nettype wire

// >>> pin_world.sv
// Partner: outside drivers on both ports, pull-up resistors on port 1 only
`timescale 1ns/100ps
`default_nettype none

module pin_world (
   // Clock
   input  wire logic       clk,
   // Device pads
   input  wire logic [7:0] p1_out,
   input  wire logic [7:0] p1_oe,
   input  wire logic [7:0] p1_pu,
   input  wire logic [2:0] p2_out,
   input  wire logic [2:0] p2_oe,
   // Outside drivers
   input  wire logic [7:0] en1,
   input  wire logic [7:0] val1,
   input  wire logic [2:0] en2,
   input  wire logic [2:0] val2,
   // Wire levels
   output logic      [7:0] p1_lvl,
   output logic      [2:0] p2_lvl
);
   // An undriven line wanders every cycle, so a stale level never reads as valid
   logic [7:0] wander = 8'h5A;
   always @(posedge clk) wander <= ~wander;
   assign p1_lvl = p1_oe & p1_out | ~p1_oe & (en1 & val1 | ~en1 & (p1_pu | wander));
   assign p2_lvl = p2_oe & p2_out | ~p2_oe & (en2 & val2 | ~en2 & wander[2:0]);
endmodule : pin_world
`default_nettype wire

// >>> tb.sv
// Testbench: registers, pads and alternate functions of the GPIO block
`timescale 1ns/100ps
`default_nettype none

module tb
   import gpio_port_pkg::*;
;
   logic       clk = 1'h0, rst_n = 1'h0, ce = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, serial_clk_in;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, en1 = 8'h00, val1 = 8'h00;
   logic [7:0] port1_pin_in, port1_pin_out, port1_pin_oe, port1_pin_pullup;
   logic [2:0] port2_pin_in, port2_pin_out, port2_pin_oe, en2 = 3'h0, val2 = 3'h0;
   logic       ext_int_line_3, ext_int_line_2, ext_int_line_1, ext_int_line_0, timer_v_trigger_in, serial_rxd;
   logic       timer_a_clock_out = 1'h0, serial_txd = 1'h0, serial_receiver_enable = 1'h0;
   logic       serial_clk_out_en = 1'h0, serial_clk_in_en = 1'h0, serial_clk_out = 1'h0;
   int         failures = 0, n_checks = 0;

   always #50 clk = ~clk;

   port1_port2_gpio_control port1_port2_gpio_control_i (.clk, .rst_n, .ce, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .port1_pin_in, .port1_pin_out, .port1_pin_oe, .port1_pin_pullup, .port2_pin_in,
      .port2_pin_out, .port2_pin_oe, .ext_int_line_3, .ext_int_line_2, .ext_int_line_1, .ext_int_line_0,
      .timer_v_trigger_in, .timer_a_clock_out, .serial_txd, .serial_rxd, .serial_receiver_enable,
      .serial_clk_out_en, .serial_clk_in_en, .serial_clk_out, .serial_clk_in);
   pin_world pin_world_i (.clk, .p1_out(port1_pin_out), .p1_oe(port1_pin_oe), .p1_pu(port1_pin_pullup),
      .p2_out(port2_pin_out), .p2_oe(port2_pin_oe), .en1, .val1, .en2, .val2, .p1_lvl(port1_pin_in),
      .p2_lvl(port2_pin_in));

   task automatic wrap_up();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : wrap_up

   task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("FAIL %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic wr(logic [3:0] a, logic [7:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'h1;
      @(posedge clk);
      reg_wr <= 1'h0;
   endtask : wr

   task automatic rd(logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'h1;
      @(posedge clk);
      reg_rd <= 1'h0;
      #1 d = reg_rdata;
   endtask : rd

   // Output bits give the latch, input bits the pin, reserved bits read one
   function automatic logic [7:0] port_rd(logic [7:0] dir, lat, lvl, rsvd);
      return dir & lat | ~dir & lvl | rsvd;
   endfunction : port_rd

   task automatic reset_seq();
      logic [7:0] x;
      logic [7:0] e [7];
      rst_n <= 1'h0;
      repeat (5) @(posedge clk);
      rst_n <= 1'h1;
      e = '{DIR_READBACK, val1 | P1_RSVD_MASK, P1_RSVD_MASK, PFS_RSVD_MASK, DIR_READBACK,
            {5'h00, val2} | P2_RSVD_MASK, UNMAPPED_READ};
      for (int i = 0; i < 7; i++) begin
         rd(4'(i), x);
         chk("reset read", e[i], x);
      end
      chk("reset oe", 8'h00, port1_pin_oe);
      $display("test reset done");
   endtask : reset_seq

   initial begin
      repeat (5000) @(posedge clk);
      failures++;
      wrap_up();
   end

   initial begin
      logic [7:0] d, l, u, q, lv, x;
      logic [2:0] d2, l2;
      logic       s;
      void'($urandom(32'hc6eed305));
      en1  <= 8'hFF;
      en2  <= 3'h7;
      val1 <= 8'($urandom);
      val2 <= 3'($urandom);
      reset_seq();
      for (int k = 0; k < 20; k++) begin
         d  = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : 8'($urandom);
         l  = 8'($urandom);
         u  = (k == 1) ? 8'hFF : 8'($urandom);
         q  = ~d & ~(u & 8'($urandom));
         d2 = 3'($urandom);
         l2 = 3'($urandom);
         en1  <= q;
         en2  <= ~d2;
         val1 <= 8'($urandom);
         val2 <= 3'($urandom);
         wr(OFS_PORT1_DIRECTION, d);
         wr(OFS_PORT1_OUTPUT_LATCH, l);
         wr(OFS_PORT1_PULLUP_ENABLE, u);
         wr(OFS_PORT2_DIRECTION, {5'h00, d2});
         wr(OFS_PORT2_OUTPUT_LATCH, {5'h00, l2});
         lv = q & val1 | ~q;
         rd(OFS_PORT1_OUTPUT_LATCH, x);
         chk("p1 data", port_rd(d, l, lv, P1_RSVD_MASK), x);
         chk("p1 oe", d & ~P1_RSVD_MASK, port1_pin_oe);
         chk("p1 out", d & l & 8'hF7, port1_pin_out & port1_pin_oe);
         chk("p1 pullup", u & ~d & 8'hF7, port1_pin_pullup);
         rd(OFS_PORT2_OUTPUT_LATCH, x);
         chk("p2 data", port_rd({5'h00, d2}, {5'h00, l2}, {5'h00, val2}, P2_RSVD_MASK), x);
         chk("p2 oe", {5'h00, d2}, {5'h00, port2_pin_oe});
         chk("p2 out", {5'h00, d2 & l2}, {5'h00, port2_pin_out & port2_pin_oe});
      end
      // A write while the clock enable is low must leave the pull-up register and pull-up pads untouched
      @(posedge clk);
      ce <= 1'h0;
      wr(OFS_PORT1_PULLUP_ENABLE, ~u);
      ce <= 1'h1;
      repeat (2) @(posedge clk);
      #1;
      chk("ce hold", u & ~d & 8'hF7, port1_pin_pullup);
      $display("test general io done");
      en1 <= 8'hF0;
      wr(OFS_PORT1_DIRECTION, 8'hFF);
      wr(OFS_PORT2_DIRECTION, 8'h07);
      wr(OFS_PIN_FUNCTION_SELECT, 8'hF3);
      for (int k = 0; k < 8; k++) begin
         s = (k >= 4);
         @(posedge clk);
         serial_receiver_enable <= 1'h1;
         serial_clk_in_en       <= ~s;
         serial_clk_out_en      <= 1'h1;
         en2                    <= {2'h1, ~s};
         val1                   <= 8'($urandom);
         val2                   <= 3'($urandom);
         timer_a_clock_out      <= 1'($urandom);
         serial_txd             <= 1'($urandom);
         serial_clk_out         <= 1'($urandom);
         repeat (4) @(posedge clk);
         #1;
         chk("alt in", {val1[7:4], val1[7], val2[1], val2[0] & ~s, 1'h0}, {ext_int_line_3, ext_int_line_2,
            ext_int_line_1, ext_int_line_0, timer_v_trigger_in, serial_rxd, serial_clk_in, 1'h0});
         chk("alt out", {5'h00, serial_txd, timer_a_clock_out, serial_clk_out & s}, {5'h00, port2_pin_out[2],
            port1_pin_out[0], port2_pin_out[0] & port2_pin_oe[0]});
         chk("alt oe", {6'h03, 1'h0, s}, {port1_pin_oe[7:4], port1_pin_oe[0], port2_pin_oe});
      end
      en1 <= 8'h00;
      wr(OFS_PIN_FUNCTION_SELECT, 8'h00);
      repeat (3) @(posedge clk);
      #1;
      chk("alt off", 8'h00, {ext_int_line_3, ext_int_line_2, ext_int_line_1, ext_int_line_0, 4'h0});
      chk("gp back", 8'hF7, port1_pin_oe);
      $display("test alternate done");
      @(posedge clk);
      en1               <= 8'hFF;
      en2               <= 3'h7;
      serial_clk_out_en <= 1'h0;
      reset_seq();
      wrap_up();
   end
endmodule : tb
`default_nettype wire
